// file: verilog/upr_regs.svh
// register offsets, field positions and reset values of the pin routing block
`ifndef UPR_REGS_SVH
`define UPR_REGS_SVH

// byte offsets on the register bus
`define UPR_MODE_OFS     5'h00
`define UPR_ODRAIN_OFS   5'h04
`define UPR_DIR_OFS      5'h08
`define UPR_PULLUP_OFS   5'h0c
`define UPR_LATCH_OFS    5'h10
`define UPR_PINS_OFS     5'h14

// field positions in serial_mode_reg_one
`define UPR_TXSEL_BIT    4
`define UPR_RXSEL_BIT    5
`define UPR_JOIN_BIT     7

// field positions in the per-pin registers
`define UPR_TX_BIT       0
`define UPR_RX_BIT       1
`define UPR_SERIN_BIT    2

// reset values
`define UPR_CTRL_RST     1'b0
`define UPR_PAIR_RST     2'h0
`define UPR_DATA_RST     32'h0000_0000

`endif

// file: verilog/upr_pkg.sv
// types shared by the pin routing block
package upr_pkg;

  // bus handshake phase
  typedef enum logic {
    upr_bus_idle,
    upr_bus_ack
  } upr_bus_e;

  // one bit per port pin: bit 0 transmit pin, bit 1 receive pin
  typedef logic [1:0] upr_pin_t;

endpackage

// file: verilog/upr_pad.sv
// registered driver for one port pin: style, direction, data and pull-up
`timescale 1ns/1ps

module upr_pad
  import upr_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // pin settings
  input  wire logic dir_out,
  input  wire logic open_drain,
  input  wire logic data,
  input  wire logic pull_en,
  // pad side
  output logic      pad_out,
  output logic      pad_oe,
  output logic      pad_pu
);

  logic out_reg;
  logic out_next;
  logic oe_reg;
  logic oe_next;
  logic pu_reg;
  logic pu_next;

  //////////////////////////////////////////////////////////////////////////
  // open drain only sinks: a one releases the pin to the pull-up
  always_comb
  begin
    pu_next = pull_en;
    if (open_drain)
    begin
      out_next = 1'b0;
      oe_next  = dir_out & ~data;
    end
    else
    begin
      out_next = data;
      oe_next  = dir_out;
    end
  end

  // registered so the pad never sees a glitch from the select muxes
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      out_reg <= 1'b0;
      oe_reg  <= 1'b0;
      pu_reg  <= 1'b0;
    end
    else
    begin
      out_reg <= out_next;
      oe_reg  <= oe_next;
      pu_reg  <= pu_next;
    end
  end

  assign pad_out = out_reg;
  assign pad_oe  = oe_reg;
  assign pad_pu  = pu_reg;

endmodule // upr_pad

// file: verilog/upr_pin_routing.sv
// pin routing of one asynchronous serial channel onto two port pins
//
// Decided for this implementation: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`include "upr_regs.svh"

module upr_pin_routing
  import upr_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // avalon-mm slave
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // serial unit side
  input  wire logic        ser_txd,
  output logic             ser_rxd,
  output logic             pins_joined,
  // transmit pin
  input  wire logic        tx_pin_in,
  output logic             tx_pin_out,
  output logic             tx_pin_oe,
  output logic             tx_pin_pu,
  // receive pin
  input  wire logic        rx_pin_in,
  output logic             rx_pin_out,
  output logic             rx_pin_oe,
  output logic             rx_pin_pu
);

  upr_bus_e    bus_reg;
  upr_bus_e    bus_next;
  logic        wait_reg;
  logic        wait_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        join_reg;
  logic        join_next;
  logic        txsel_reg;
  logic        txsel_next;
  logic        rxsel_reg;
  logic        rxsel_next;
  logic        od_reg;
  logic        od_next;
  upr_pin_t    dir_reg;
  upr_pin_t    dir_next;
  upr_pin_t    pu_reg;
  upr_pin_t    pu_next;
  upr_pin_t    latch_reg;
  upr_pin_t    latch_next;
  logic        rxd_reg;
  logic        rxd_next;
  logic        wr_go;
  upr_pin_t    pin_data;
  upr_pin_t    pin_od;
  upr_pin_t    pad_out;
  upr_pin_t    pad_oe;
  upr_pin_t    pad_pu;

  //////////////////////////////////////////////////////////////////////////
  // bus handshake: waitrequest drops one cycle after a request appears
  always_comb
  begin
    bus_next   = upr_bus_idle;
    rdata_next = rdata_reg;
    if (bus_reg == upr_bus_idle && (read || write))
      bus_next = upr_bus_ack;
    if (bus_reg == upr_bus_idle && read)
    begin
      rdata_next = `UPR_DATA_RST;
      case (address)
        `UPR_MODE_OFS:
        begin
          rdata_next[`UPR_TXSEL_BIT] = txsel_reg;
          rdata_next[`UPR_RXSEL_BIT] = rxsel_reg;
          rdata_next[`UPR_JOIN_BIT]  = join_reg;
        end
        `UPR_ODRAIN_OFS: rdata_next[`UPR_TX_BIT] = od_reg;
        `UPR_DIR_OFS:    rdata_next[1:0] = dir_reg;
        `UPR_PULLUP_OFS: rdata_next[1:0] = pu_reg;
        `UPR_LATCH_OFS:  rdata_next[1:0] = latch_reg;
        `UPR_PINS_OFS:
        begin
          rdata_next[`UPR_TX_BIT]    = tx_pin_in;
          rdata_next[`UPR_RX_BIT]    = rx_pin_in;
          rdata_next[`UPR_SERIN_BIT] = rxd_reg;
        end
        default:         rdata_next = `UPR_DATA_RST; // unmapped reads zero
      endcase
    end
    wait_next = (bus_next != upr_bus_ack);
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      bus_reg   <= upr_bus_idle;
      wait_reg  <= 1'b1;
      rdata_reg <= `UPR_DATA_RST;
    end
    else
    begin
      bus_reg   <= bus_next;
      wait_reg  <= wait_next;
      rdata_reg <= rdata_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // control registers: a write lands on the edge that sees waitrequest low
  assign wr_go = write && (bus_reg == upr_bus_ack) && byteenable[0];

  always_comb
  begin
    join_next  = join_reg;
    txsel_next = txsel_reg;
    rxsel_next = rxsel_reg;
    od_next    = od_reg;
    dir_next   = dir_reg;
    pu_next    = pu_reg;
    latch_next = latch_reg;
    if (wr_go)
    begin
      case (address)
        `UPR_MODE_OFS:
        begin
          join_next  = writedata[`UPR_JOIN_BIT];
          txsel_next = writedata[`UPR_TXSEL_BIT];
          rxsel_next = writedata[`UPR_RXSEL_BIT];
        end
        `UPR_ODRAIN_OFS: od_next    = writedata[`UPR_TX_BIT];
        `UPR_DIR_OFS:    dir_next   = writedata[1:0];
        `UPR_PULLUP_OFS: pu_next    = writedata[1:0];
        `UPR_LATCH_OFS:  latch_next = writedata[1:0];
        default:         join_next  = join_reg; // unmapped writes ignored
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      join_reg  <= `UPR_CTRL_RST;
      txsel_reg <= `UPR_CTRL_RST;
      rxsel_reg <= `UPR_CTRL_RST;
      od_reg    <= `UPR_CTRL_RST;
      dir_reg   <= `UPR_PAIR_RST;
      pu_reg    <= `UPR_PAIR_RST;
      latch_reg <= `UPR_PAIR_RST;
    end
    else
    begin
      join_reg  <= join_next;
      txsel_reg <= txsel_next;
      rxsel_reg <= rxsel_next;
      od_reg    <= od_next;
      dir_reg   <= dir_next;
      pu_reg    <= pu_next;
      latch_reg <= latch_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // serial input select; joined mode ignores the receive pin entirely
  always_comb
  begin
    if (!rxsel_reg)
      rxd_next = 1'b1;
    else if (join_reg)
      rxd_next = tx_pin_in;
    else
      rxd_next = rx_pin_in;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      rxd_reg <= 1'b1;
    else
      rxd_reg <= rxd_next;
  end

  //////////////////////////////////////////////////////////////////////////
  // pad data: the join bit plays no part here, so transmit setup is shared
  assign pin_data[`UPR_TX_BIT] = txsel_reg ? ser_txd
                                           : latch_reg[`UPR_TX_BIT];
  assign pin_data[`UPR_RX_BIT] = latch_reg[`UPR_RX_BIT];
  assign pin_od[`UPR_TX_BIT]   = od_reg;
  assign pin_od[`UPR_RX_BIT]   = 1'b0;

  // one registered pad driver per port pin
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_pad
      upr_pad u_pad
      (
        .clk        (clk),
        .nrst       (nrst),
        .dir_out    (dir_reg[gi]),
        .open_drain (pin_od[gi]),
        .data       (pin_data[gi]),
        .pull_en    (pu_reg[gi]),
        .pad_out    (pad_out[gi]),
        .pad_oe     (pad_oe[gi]),
        .pad_pu     (pad_pu[gi])
      );
    end
  endgenerate

  assign readdata    = rdata_reg;
  assign waitrequest = wait_reg;
  assign ser_rxd     = rxd_reg;
  assign pins_joined = join_reg;
  assign tx_pin_out  = pad_out[`UPR_TX_BIT];
  assign tx_pin_oe   = pad_oe[`UPR_TX_BIT];
  assign tx_pin_pu   = pad_pu[`UPR_TX_BIT];
  assign rx_pin_out  = pad_out[`UPR_RX_BIT];
  assign rx_pin_oe   = pad_oe[`UPR_RX_BIT];
  assign rx_pin_pu   = pad_pu[`UPR_RX_BIT];

  //////////////////////////////////////////////////////////////////////////
  // checks on routing and pad behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  join_rx_src_a: assert property (rxsel_reg && join_reg |=>
    ser_rxd == $past(tx_pin_in)) else $error("joined rx not from tx pin");
  sep_rx_src_a: assert property (rxsel_reg && !join_reg |=>
    ser_rxd == $past(rx_pin_in)) else $error("separate rx not from rx pin");
  idle_rx_one_a: assert property (!rxsel_reg |=> ser_rxd)
    else $error("unselected serial input not one");
  tx_serial_a: assert property (txsel_reg && !od_reg && dir_reg[0] |=>
    tx_pin_oe && tx_pin_out == $past(ser_txd))
    else $error("serial output not on tx pin");
  tx_latch_a: assert property (!txsel_reg && !od_reg |=>
    tx_pin_out == $past(latch_reg[0])) else $error("tx pin not from latch");
  open_drain_a: assert property (od_reg |=> !tx_pin_out)
    else $error("open drain drove high");
  od_release_a: assert property (od_reg && dir_reg[0] ##1 od_reg
    |-> tx_pin_oe == !$past(pin_data[0])) else $error("open drain enable");
  tx_dir_a: assert property (!dir_reg[0] |=> !tx_pin_oe)
    else $error("tx pin driven as input");
  tx_pullup_a: assert property (pu_reg[0] |=> tx_pin_pu)
    else $error("tx pull-up missing");
  rx_port_a: assert property (1'b1 |=> rx_pin_oe == $past(dir_reg[1])
    && (!rx_pin_oe || rx_pin_out == $past(latch_reg[1])))
    else $error("rx pin not a plain port");
  // with tx pin direction, data and open drain steady, flipping the join bit must not move its enable or output
  join_flag_a: assert property ($changed(join_reg) &&
    $stable(dir_reg[0]) && $stable(pin_data[0]) && $stable(od_reg)
    |=> $stable(tx_pin_oe) && $stable(tx_pin_out))
    else $error("join bit changed tx pin setup");
  bus_ack_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus answer late");

  join_rx_c: cover property (rxsel_reg && join_reg && !ser_rxd);
  sep_rx_c:  cover property (rxsel_reg && !join_reg && !ser_rxd);
  od_tx_c:   cover property (od_reg && txsel_reg && tx_pin_oe);
  read_c:    cover property (read && !waitrequest);

endmodule // upr_pin_routing

// file: testbench/upr_line_model.sv
// remote serial device and wire resolution on both port pins
`timescale 1ns/1ps

module upr_line_model
(
  // clock
  input  wire logic clk,
  // block side of each pin
  input  wire logic tx_out,
  input  wire logic tx_oe,
  input  wire logic tx_pu,
  input  wire logic rx_out,
  input  wire logic rx_oe,
  input  wire logic rx_pu,
  // remote drive: bit on tx line, inverse on rx line
  input  wire logic drv_en,
  input  wire logic drv_bit,
  // resolved levels
  output logic      tx_line,
  output logic      rx_line
);
  logic flip_reg = 1'b0;

  // a floating line wanders, so a stale level is never trusted
  always @(posedge clk)
    flip_reg <= ~flip_reg;

  // block drive wins, then remote drive, then pull-up
  assign tx_line = tx_oe ? tx_out : drv_en ? drv_bit : tx_pu | flip_reg;
  assign rx_line = rx_oe ? rx_out : drv_en ? ~drv_bit : rx_pu | flip_reg;
endmodule // upr_line_model

// file: testbench/tb.sv
// self-checking bench of the serial pin routing block
`timescale 1ns/1ps
`include "upr_regs.svh"

module tb
  import upr_pkg::*;
;
  typedef struct {
    logic [7:0] mode;
    logic       od;
    logic [1:0] dir, pu, lat;
    logic       txd;
    logic [5:0] pins; // tx out/oe/pu, rx out/oe/pu
  } upr_row_s;

  logic        clk, nrst, read, write, waitrequest, ser_txd, ser_rxd, e;
  logic        pins_joined, tx_pin_in, tx_pin_out, tx_pin_oe, tx_pin_pu;
  logic        rx_pin_in, rx_pin_out, rx_pin_oe, rx_pin_pu, drv_en, drv_bit;
  logic [4:0]  address;
  logic [3:0]  byteenable;
  logic [31:0] writedata, readdata, rd;
  int          n_errors, cmp_count, cycles;
  upr_row_s    rows [6] = '{
    '{8'h10, 1'b0, 2'h1, 2'h1, 2'h0, 1'b1, 6'h38},
    '{8'h10, 1'b1, 2'h1, 2'h1, 2'h0, 1'b1, 6'h08},
    '{8'h10, 1'b1, 2'h1, 2'h1, 2'h0, 1'b0, 6'h18},
    '{8'h90, 1'b0, 2'h3, 2'h2, 2'h2, 1'b0, 6'h17},
    '{8'h00, 1'b0, 2'h1, 2'h0, 2'h1, 1'b0, 6'h30},
    '{8'h20, 1'b0, 2'h0, 2'h0, 2'h0, 1'b1, 6'h00}};

  upr_pin_routing uut (.clk, .nrst, .address, .read, .write, .writedata,
    .byteenable, .readdata, .waitrequest, .ser_txd, .ser_rxd, .pins_joined,
    .tx_pin_in, .tx_pin_out, .tx_pin_oe, .tx_pin_pu, .rx_pin_in,
    .rx_pin_out, .rx_pin_oe, .rx_pin_pu);
  upr_line_model line (.clk, .tx_out(tx_pin_out), .tx_oe(tx_pin_oe),
    .tx_pu(tx_pin_pu), .rx_out(rx_pin_out), .rx_oe(rx_pin_oe),
    .rx_pu(rx_pin_pu), .drv_en, .drv_bit, .tx_line(tx_pin_in),
    .rx_line(rx_pin_in));

  //////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_errors++;
      stop_test();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // request held until waitrequest is sampled low; an edge then passes
  // no local limit: only the cycle guard above ends a hung wait
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    address <= a;
    writedata <= d;
    byteenable <= be;
    write <= wr;
    read <= ~wr;
    do
    begin
      @(posedge clk);
    end
    while (waitrequest !== 1'b0);
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clk);
  endtask

  // reset state of every block output except readdata
  task automatic check_reset();
    check("reset", {waitrequest, ser_rxd, pins_joined, tx_pin_out, tx_pin_oe,
      tx_pin_pu, rx_pin_out, rx_pin_oe, rx_pin_pu}, 32'h180);
  endtask

  task automatic stop_test();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    {nrst, read, write, ser_txd, drv_en, drv_bit} = 6'h00;
    {address, byteenable, writedata} = '0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    check_reset();
    // table of pin settings against pad outputs
    foreach (rows[i])
    begin
      ser_txd <= rows[i].txd;
      bus(1, `UPR_MODE_OFS, 32'(rows[i].mode), 4'hf);
      bus(1, `UPR_ODRAIN_OFS, 32'(rows[i].od), 4'hf);
      bus(1, `UPR_DIR_OFS, 32'(rows[i].dir), 4'hf);
      bus(1, `UPR_PULLUP_OFS, 32'(rows[i].pu), 4'hf);
      bus(1, `UPR_LATCH_OFS, 32'(rows[i].lat), 4'hf);
      repeat (2) @(posedge clk);
      check("pins", {tx_pin_out, tx_pin_oe, tx_pin_pu, rx_pin_out, rx_pin_oe,
        rx_pin_pu}, 32'(rows[i].pins));
      check("tx pins", {tx_pin_out, tx_pin_oe, tx_pin_pu},
        32'(rows[i].pins[5:3]));
      // mode, open drain, pull-up and latch registers read back what was written
      bus(0, `UPR_MODE_OFS, 0, 4'hf);
      check("mode reg", rd, 32'(rows[i].mode));
      bus(0, `UPR_ODRAIN_OFS, 0, 4'hf);
      check("od reg", rd, 32'(rows[i].od));
      bus(0, `UPR_PULLUP_OFS, 0, 4'hf);
      check("pu reg", rd, 32'(rows[i].pu));
      bus(0, `UPR_LATCH_OFS, 0, 4'hf);
      check("latch reg", rd, 32'(rows[i].lat));
    end
    // reception: separate, joined, unselected; both line levels differ
    drv_en <= 1'b1;
    for (int m = 0; m < 3; m++)
      for (int b = 0; b < 2; b++)
      begin
        drv_bit <= b[0];
        bus(1, `UPR_MODE_OFS, m == 0 ? 32'h20 : m == 1 ? 32'ha0 : 0, 4'hf);
        repeat (2) @(posedge clk);
        e = m == 0 ? !b[0] : m == 1 ? b[0] : 1'b1;
        check("ser_rxd", 32'(ser_rxd), 32'(e));
        check("pins_joined", 32'(pins_joined), 32'(m == 1));
        bus(0, `UPR_PINS_OFS, 0, 4'hf);
        check("pins reg", rd, {29'h0, e, !b[0], b[0]});
      end
    // unmapped place and disabled byte lane store nothing
    bus(1, 5'h18, 32'hff, 4'hf);
    bus(0, 5'h18, 0, 4'hf);
    check("unmapped", rd, 0);
    bus(1, `UPR_DIR_OFS, 32'h3, 4'h0);
    bus(0, `UPR_DIR_OFS, 0, 4'hf);
    check("dir lane off", rd, 0);
    bus(1, `UPR_DIR_OFS, 32'h3, 4'h1);
    bus(0, `UPR_DIR_OFS, 0, 4'hf);
    check("dir", rd, 32'h3);
    // second reset in mid-run
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    check_reset();
    bus(0, `UPR_DIR_OFS, 0, 4'hf);
    check("dir after reset", rd, 0);
    stop_test();
  end
endmodule // tb
